// >>> logic/conv_cfg_alert.v
// configuration register, auto-conversion timer and alert control
// Contract
// R1: interval code zero disables automatic conversion
// R2: nonzero interval code starts automatic conversion
// R3: spacing is conversion time times 32..2048
// R4: unlatched alerts self-clear past hysteresis
// R5: latched alerts clear only by writing one
// R6: pin enable zero floats the alert pin
// R7: result bit 15 mirrors alerts when enabled
// R8: over-range sets above upper, clears below upper-hyst
// R9: under-range sets below lower, clears above lower+hyst
// R10: config bit 0 selects alert pin level
`timescale 1ns/1ps
`include "conv_cfg_defs.vh"
// =====================================================
// one alert flag: set wins, cleared by software or hysteresis
module range_flag #(
  parameter [0:0] RESET_VAL = 1'b0
) (
  input wire sys_clk,
  input wire nrst,
  input wire set_evt,
  input wire self_clr,
  input wire sw_clr,
  output wire flag
);
reg flag_r;
reg flag_nxt;
// =====================================================
// next state
always @* begin
  flag_nxt = flag_r;
  if (set_evt) begin
    flag_nxt = 1'b1;
  end else if (sw_clr) begin
    flag_nxt = 1'b0; // R5
  end else if (self_clr) begin
    flag_nxt = 1'b0; // R4
  end
end
// =====================================================
// flag register
always @(posedge sys_clk or negedge nrst) begin
  if (!nrst) begin
    flag_r <= RESET_VAL;
  end else begin
    flag_r <= flag_nxt;
  end
end
assign flag = flag_r;
endmodule
// =====================================================
// automatic conversion interval timer
module interval_timer #(
  parameter CONV_CYCLES = `CONV_CYCLES_DEFAULT,
  parameter CNT_W = 32
) (
  input wire sys_clk,
  input wire nrst,
  input wire [2:0] interval,
  output wire run,
  output wire start
);
localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
localparam [CNT_W-1:0] BASE = CONV_CYCLES;
reg [CNT_W-1:0] tick_r;
reg [CNT_W-1:0] tick_nxt;
wire [5:0] shift_amt;
wire [CNT_W-1:0] period;
wire [CNT_W-1:0] last_tick;
// =====================================================
// mode decode
assign run = (interval != 3'h0); // R1 R2
// =====================================================
// interval length: base shift 5 gives times 32 for code 1
assign shift_amt = `INTERVAL_BASE_SHIFT + {3'h0, interval} - 6'h01; // R3
assign period = BASE << shift_amt; // R3
assign last_tick = period - CNT_ONE;
// =====================================================
// tick counter, held at zero while idle
always @* begin
  tick_nxt = tick_r + CNT_ONE;
  if (!run || tick_r >= last_tick) begin
    tick_nxt = CNT_ZERO;
  end
end
always @(posedge sys_clk or negedge nrst) begin
  if (!nrst) begin
    tick_r <= CNT_ZERO;
  end else begin
    tick_r <= tick_nxt;
  end
end
// first start comes in the same cycle the mode is entered
assign start = run && (tick_r == CNT_ZERO); // R2 R3
endmodule
// =====================================================
// configuration register and alert control
module conv_cfg_alert #(
  parameter CONV_CYCLES = 100
) (
  input wire sys_clk,
  input wire nrst,
  input wire [2:0] reg_ptr,
  input wire reg_wr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata,
  input wire conv_done,
  input wire [7:0] conv_value,
  output wire conv_start,
  output wire auto_mode,
  output wire alert_out,
  output wire alert_oe
);
// =====================================================
// registers
reg [7:0] cfg_r;
reg [7:0] cfg_nxt;
reg [7:0] upper_r;
reg [7:0] upper_nxt;
reg [7:0] lower_r;
reg [7:0] lower_nxt;
reg [7:0] hyst_r;
reg [7:0] hyst_nxt;
reg [7:0] result_r;
reg [7:0] result_nxt;
wire [2:0] interval;
wire hold;
wire flag_en;
wire [7:0] wr_field;
wire [7:0] wr_cfg;
wire cfg_wr;
wire lower_wr;
wire upper_wr;
wire hyst_wr;
wire st_wr;
wire over_r;
wire under_r;
wire any_alert;
assign interval = cfg_r[`CFG_INTERVAL_HI:`CFG_INTERVAL_LO];
assign hold = cfg_r[`CFG_HOLD_BIT];
assign flag_en = cfg_r[`CFG_FLAG_EN_BIT];
// =====================================================
// write decode
assign wr_field = reg_wdata[`FIELD_HI:`FIELD_LO];
// reserved bit 1 always reads zero
assign wr_cfg = reg_wdata[7:0] & `CFG_WRITE_MASK;
assign cfg_wr = reg_wr && (reg_ptr == `PTR_CONFIG);
assign lower_wr = reg_wr && (reg_ptr == `PTR_LOWER_LIMIT);
assign upper_wr = reg_wr && (reg_ptr == `PTR_UPPER_LIMIT);
assign hyst_wr = reg_wr && (reg_ptr == `PTR_HYSTERESIS);
assign st_wr = reg_wr && (reg_ptr == `PTR_ALERT_STATUS);
// =====================================================
// register next values
always @* begin
  cfg_nxt = cfg_r;
  upper_nxt = upper_r;
  lower_nxt = lower_r;
  hyst_nxt = hyst_r;
  result_nxt = result_r;
  if (cfg_wr) begin
    cfg_nxt = wr_cfg;
  end
  if (lower_wr) begin
    lower_nxt = wr_field;
  end
  if (upper_wr) begin
    upper_nxt = wr_field;
  end
  if (hyst_wr) begin
    hyst_nxt = wr_field;
  end
  if (conv_done) begin
    result_nxt = conv_value;
  end
end
always @(posedge sys_clk or negedge nrst) begin
  if (!nrst) begin
    cfg_r <= `CFG_RESET;
    upper_r <= `UPPER_LIMIT_RESET;
    lower_r <= `LOWER_LIMIT_RESET;
    hyst_r <= `HYST_RESET;
    result_r <= `RESULT_RESET;
  end else begin
    cfg_r <= cfg_nxt;
    upper_r <= upper_nxt;
    lower_r <= lower_nxt;
    hyst_r <= hyst_nxt;
    result_r <= result_nxt;
  end
end
// =====================================================
// automatic conversion timer
interval_timer #(
  .CONV_CYCLES(CONV_CYCLES),
  .CNT_W(32)
) timer_u (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .interval(interval),
  .run(auto_mode),
  .start(conv_start)
); // R1 R2 R3
// =====================================================
// limit comparison
wire [8:0] up_clear;
wire [8:0] lo_clear;
wire over_set;
wire under_set;
wire over_self;
wire under_self;
wire over_sw;
wire under_sw;
assign up_clear = {1'b0, upper_r} - {1'b0, hyst_r};
assign lo_clear = {1'b0, lower_r} + {1'b0, hyst_r};
assign over_set = conv_done && (conv_value > upper_r); // R8
assign under_set = conv_done && (conv_value < lower_r); // R9
// no self-clear when hysteresis exceeds the upper limit
assign over_self = conv_done && !hold && !up_clear[8] &&
  ({1'b0, conv_value} < up_clear); // R4 R8
assign under_self = conv_done && !hold &&
  ({1'b0, conv_value} > lo_clear); // R4 R9
assign over_sw = st_wr && reg_wdata[`STATUS_OVER_BIT]; // R5
assign under_sw = st_wr && reg_wdata[`STATUS_UNDER_BIT]; // R5
// =====================================================
// alert flags
range_flag #(
  .RESET_VAL(1'b0)
) over_u (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .set_evt(over_set),
  .self_clr(over_self),
  .sw_clr(over_sw),
  .flag(over_r)
); // R8
range_flag #(
  .RESET_VAL(1'b0)
) under_u (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .set_evt(under_set),
  .self_clr(under_self),
  .sw_clr(under_sw),
  .flag(under_r)
); // R9
// =====================================================
// read data and alert pin
assign any_alert = over_r | under_r;
always @* begin
  case (reg_ptr)
    `PTR_RESULT: reg_rdata = {flag_en & any_alert, 3'h0,
      result_r, 4'h0}; // R7
    `PTR_ALERT_STATUS: reg_rdata = {14'h0, over_r, under_r};
    `PTR_CONFIG: reg_rdata = {8'h00, cfg_r};
    `PTR_LOWER_LIMIT: reg_rdata = {4'h0, lower_r, 4'h0};
    `PTR_UPPER_LIMIT: reg_rdata = {4'h0, upper_r, 4'h0};
    `PTR_HYSTERESIS: reg_rdata = {4'h0, hyst_r, 4'h0};
    default: reg_rdata = 16'h0000;
  endcase
end
assign alert_oe = cfg_r[`CFG_PIN_EN_BIT]; // R6
assign alert_out = any_alert ~^ cfg_r[`CFG_POLARITY_BIT]; // R10
endmodule

// >>> shared/conv_cfg_defs.vh
// constants for the converter configuration and alert control block
`ifndef CONV_CFG_DEFS_VH
`define CONV_CFG_DEFS_VH
`define PTR_RESULT 3'h0
`define PTR_ALERT_STATUS 3'h1
`define PTR_CONFIG 3'h2
`define PTR_LOWER_LIMIT 3'h3
`define PTR_UPPER_LIMIT 3'h4
`define PTR_HYSTERESIS 3'h5
`define CFG_RESET 8'h00
`define CFG_INTERVAL_HI 7
`define CFG_INTERVAL_LO 5
`define CFG_HOLD_BIT 4
`define CFG_FLAG_EN_BIT 3
`define CFG_PIN_EN_BIT 2
`define CFG_POLARITY_BIT 0
`define CFG_WRITE_MASK 8'hfd
`define UPPER_LIMIT_RESET 8'hff
`define LOWER_LIMIT_RESET 8'h00
`define HYST_RESET 8'h00
`define INTERVAL_BASE_SHIFT 6'h05
`define CONV_CYCLES_DEFAULT 32'h00000064
`define RESULT_RESET 8'h00
`define FIELD_HI 11
`define FIELD_LO 4
`define STATUS_OVER_BIT 1
`define STATUS_UNDER_BIT 0
`endif

// >>> sim/cfg_mon_monitor.sv
// port checker for config and alert control
`timescale 1ns/1ps
module cfg_mon (
  input wire sys_clk,
  input wire nrst,
  input wire reg_wr,
  input wire conv_start,
  input wire auto_mode,
  input wire alert_oe,
  input wire [2:0] reg_ptr,
  input wire [15:0] reg_wdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_on;
    reg_wr && reg_ptr == 3'h2 && reg_wdata[7:5] != 3'h0 |=> auto_mode;
  endproperty
  a_on: assert property (p_on) else $error("auto mode not entered");
  property p_off;
    reg_wr && reg_ptr == 3'h2 && reg_wdata[7:5] == 3'h0 |=> !auto_mode;
  endproperty
  a_off: assert property (p_off) else $error("auto mode not left");
  property p_of;
    !auto_mode |-> !conv_start;
  endproperty
  a_of: assert property (p_of) else $error("start while idle");
  property p_gp;
    conv_start |=> !conv_start [*8];
  endproperty
  a_gp: assert property (p_gp) else $error("starts too close");
  property p_oe;
    reg_wr && reg_ptr == 3'h2 && !reg_wdata[2] |=> !alert_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("pin not released");
  property p_oe_on;
    reg_wr && reg_ptr == 3'h2 && reg_wdata[2] |=> alert_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("pin not enabled");
endmodule
bind conv_cfg_alert cfg_mon mon_u (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .reg_wr(reg_wr),
  .conv_start(conv_start),
  .auto_mode(auto_mode),
  .alert_oe(alert_oe),
  .reg_ptr(reg_ptr),
  .reg_wdata(reg_wdata)
);

// >>> sim/core_m.sv
// conversion core model
`timescale 1ns/1ps
module core_m(input wire sys_clk,nrst,conv_start,input wire [7:0] vin,
  output reg conv_done,output reg [7:0] conv_value);
  always @(posedge sys_clk or negedge nrst)
    if(!nrst) {conv_done,conv_value}<=9'h0;
    else {conv_done,conv_value}<={conv_start,conv_start?vin:~conv_value};
endmodule

// >>> sim/tb_conv_cfg_alert.sv
// bench for config and alert control
`timescale 1ns/1ps
module tb_conv_cfg_alert;
  localparam int SIM_CONV = 2;
  reg sys_clk = 1'b0;
  reg nrst = 1'b0;
  reg reg_wr = 1'b0;
  reg [2:0] reg_ptr = 3'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg [7:0] vin = 8'h00;
  reg [7:0] u;
  reg p;
  wire [15:0] reg_rdata;
  wire [7:0] conv_value;
  wire conv_done;
  wire conv_start;
  wire auto_mode;
  wire alert_out;
  wire alert_oe;
  int mismatches = 0;
  int n_compared = 0;
  int t;
  int n;
  conv_cfg_alert #(.CONV_CYCLES(SIM_CONV)) dut_u (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .reg_ptr(reg_ptr),
    .reg_wr(reg_wr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .conv_done(conv_done),
    .conv_value(conv_value),
    .conv_start(conv_start),
    .auto_mode(auto_mode),
    .alert_out(alert_out),
    .alert_oe(alert_oe)
  );
  core_m core_u (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .conv_start(conv_start),
    .vin(vin),
    .conv_done(conv_done),
    .conv_value(conv_value)
  );
  initial begin
    forever begin
      #5 sys_clk = ~sys_clk;
    end
  end
  // cycles between starts: conversion time times 32 << (code - 1)
  function [15:0] exp_period(input int code);
    exp_period = 16'(SIM_CONV * (32 << (code - 1)));
  endfunction
  task chk(input [15:0] g, input [15:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task rd(input [2:0] a, input [15:0] e);
    reg_ptr = a;
    #1;
    chk(reg_rdata, e);
  endtask
  task wr(input [2:0] a, input [15:0] d);
    @(posedge sys_clk);
    #1;
    reg_ptr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
  endtask
  task cv(input [7:0] v);
    @(posedge sys_clk);
    #1;
    vin = v;
    repeat (70) @(posedge sys_clk);
    #1;
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(46));
    repeat (4) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    chk(auto_mode, 1'b0);
    chk(alert_oe, 1'b0);
    chk(alert_out, 1'b1);
    for (n = 1; n < 8; n++) begin
      wr(3'h2, 16'h0000);
      wr(3'h2, {8'h00, n[2:0], 5'h00});
      chk(auto_mode, 1'b1);
      t = 0;
      do begin
        @(posedge sys_clk);
        #1;
        t++;
      end while (!conv_start && t < 5000);
      if (t >= 5000) begin
        mismatches++;
        $display("[FAIL] %0t timer wait ran out", $time);
        final_report;
      end
      chk(t[15:0], exp_period(n));
    end
    wr(3'h2, 16'h0000);
    chk(auto_mode, 1'b0);
    chk(conv_start, 1'b0);
    u = 8'($urandom_range(191, 64));
    p = 1'($urandom_range(1, 0));
    wr(3'h4, {4'h0, u, 4'h0});
    wr(3'h3, {4'h0, u - 8'h30, 4'h0});
    wr(3'h5, 16'h0100);
    rd(3'h4, {4'h0, u, 4'h0});
    vin = u + 8'h01;
    wr(3'h2, {8'h00, 7'h17, p});
    rd(3'h2, {8'h00, 7'h16, p});
    chk(alert_oe, 1'b1);
    cv(u + 8'h01);
    rd(3'h1, 16'h0002);
    chk(alert_out, p);
    rd(3'h0, {4'h8, u + 8'h01, 4'h0});
    cv(u - 8'h08);
    rd(3'h1, 16'h0002);
    cv(u - 8'h11);
    rd(3'h1, 16'h0000);
    chk(alert_out, !p);
    cv(u - 8'h31);
    rd(3'h1, 16'h0001);
    cv(u - 8'h1f);
    rd(3'h1, 16'h0000);
    wr(3'h2, {8'h00, 7'h1e, p});
    cv(u - 8'h31);
    cv(u - 8'h10);
    rd(3'h1, 16'h0001);
    wr(3'h1, 16'h0001);
    rd(3'h1, 16'h0000);
    rd(3'h0, {4'h0, u - 8'h10, 4'h0});
    wr(3'h2, 16'h0000);
    chk(alert_oe, 1'b0);
    final_report;
  end
endmodule
